// *** dv/mtpsc_pad_ctrl_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module mtpsc_pad_ctrl_monitor (
	input wire logic clk,                      // clock
	input wire logic rst_n,                    // reset
	input wire logic chan_a_powerdown_pin_low, // pin a
	input wire logic chan_b_powerdown_pin_low, // pin b
	input wire logic chan_a_pd_bit,            // bit a
	input wire logic chan_b_pd_bit,            // bit b
	input wire logic mdio_read_drive,          // drive request
	input wire logic mdio_oe,                  // mdio enable
	input wire logic mgmt_active,              // mgmt usable
	input wire logic status_valid,             // status ok
	input wire logic test_reset_low,           // test reset
	input wire logic tdo_oe,                   // tdo enable
	input wire logic tdi_pullup_en,            // tdi pull
	input wire logic tms_pullup_en,            // tms pull
	input wire logic trst_pulldown_en,         // trst pull
	input wire logic scan_enabled              // scan active
);
	// ==========
	// checks; five samples cover the pin synchroniser latency
	wire logic pinpd = !chan_a_powerdown_pin_low & !chan_b_powerdown_pin_low;
	wire logic regpd = chan_a_pd_bit & chan_b_pd_bit;
	wire logic pulls = tdi_pullup_en & tms_pullup_en & trst_pulldown_en;
	wire logic anypull = tdi_pullup_en | tms_pullup_en | trst_pulldown_en;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_pin_pd;
		pinpd [*5];
	endsequence
	sequence s_pins_up;
		!pinpd [*5];
	endsequence
	a_reset_float: assert property ($rose(rst_n) |-> !mdio_oe && !tdo_oe)
		else $error("pads driven at reset release");
	a_pin_pd_float: assert property (s_pin_pd |-> !mdio_oe && !tdo_oe && !mgmt_active)
		else $error("pads driven in pin powerdown");
	a_pin_pd_pulls: assert property (s_pin_pd |-> !anypull)
		else $error("pulls on in pin powerdown");
	a_mgmt_stays_up: assert property (s_pins_up |-> mgmt_active)
		else $error("management lost");
	a_mdio_read_drive: assert property (s_pins_up ##0 mdio_read_drive |=> mdio_oe)
		else $error("mdio not driven on read");
	a_reg_pd_pulls: assert property ((regpd && !pinpd) [*5] |-> pulls)
		else $error("pulls off in register powerdown");
	a_reg_pd_tdo: assert property (regpd [*2] |-> !tdo_oe)
		else $error("tdo driven in register powerdown");
	a_status_invalid: assert property (regpd |-> !status_valid)
		else $error("status marked valid in powerdown");
	a_scan_off_float: assert property (!test_reset_low [*6] |-> !tdo_oe && !scan_enabled)
		else $error("tdo or scan active under test reset");
endmodule
bind mtpsc_pad_ctrl mtpsc_pad_ctrl_monitor mon (.clk, .rst_n,
	.chan_a_powerdown_pin_low, .chan_b_powerdown_pin_low, .chan_a_pd_bit,
	.chan_b_pd_bit, .mdio_read_drive, .mdio_oe, .mgmt_active, .status_valid,
	.test_reset_low, .tdo_oe, .tdi_pullup_en, .tms_pullup_en,
	.trst_pulldown_en, .scan_enabled);
`default_nettype wire

// *** dv/mtpsc_pad_ctrl_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module mtpsc_pad_ctrl_test;
	import mtpsc_pkg::*;
	logic clk, rst_n, chan_a_powerdown_pin_low, chan_b_powerdown_pin_low;
	logic chan_a_pd_bit, chan_b_pd_bit, mdio_read_drive, mdio_core_out;
	logic mdio_out, mdio_oe, mgmt_active, status_valid, tdo_out, tdo_oe;
	logic tdi_pullup_en, tms_pullup_en, trst_pulldown_en, scan_enabled;
	logic [3:0] instr;
	wire logic tck, tms, tdi, test_reset_low;
	int n_errors = 0;
	int n_compared = 0;
	int i;
	mtpsc_pad_ctrl uut (.clk, .rst_n, .chan_a_powerdown_pin_low,
		.chan_b_powerdown_pin_low, .chan_a_pd_bit, .chan_b_pd_bit,
		.mdio_read_drive, .mdio_core_out, .mdio_out, .mdio_oe, .mgmt_active,
		.status_valid, .tck, .tms, .tdi, .test_reset_low, .tdo_out, .tdo_oe,
		.tdi_pullup_en, .tms_pullup_en, .trst_pulldown_en, .scan_enabled,
		.instr);
	mtpsc_tester tst (.clk, .tck, .tms, .tdi, .test_reset_low);
	// ==========
	// checking and scenarios
	task automatic check(input logic seen, input logic exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: saw %b not %b", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		if (n_errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic pads(input logic a, input logic b, input logic ba,
		input logic bb);
		chan_a_powerdown_pin_low = a;
		chan_b_powerdown_pin_low = b;
		chan_a_pd_bit = ba;
		chan_b_pd_bit = bb;
		repeat (5) @(negedge clk);
	endtask
	task automatic t_reg_pd();
		pads(1'h1, 1'h1, 1'h1, 1'h0);
		check(status_valid, 1'h1);
		check(mdio_out, 1'h1);
		mdio_read_drive = 1'h0;
		mdio_core_out = 1'h0;
		repeat (2) @(negedge clk);
		check(mdio_oe, 1'h0);
		check(mdio_out, 1'h0);
		mdio_read_drive = 1'h1;
		mdio_core_out = 1'h1;
		pads(1'h1, 1'h1, 1'h1, 1'h1);
		check(mdio_oe, 1'h1);
		check(mgmt_active, 1'h1);
		check(status_valid, 1'h0);
		check(tdi_pullup_en & tms_pullup_en & trst_pulldown_en, 1'h1);
	endtask
	task automatic t_pin_pd();
		pads(1'h0, 1'h1, 1'h1, 1'h1);
		check(mdio_oe, 1'h1);
		pads(1'h0, 1'h0, 1'h1, 1'h1);
		check(mdio_oe, 1'h0);
		check(tdo_oe, 1'h0);
		check(mgmt_active, 1'h0);
		check(tdi_pullup_en | tms_pullup_en | trst_pulldown_en, 1'h0);
		pads(1'h1, 1'h1, 1'h0, 1'h0);
		check(trst_pulldown_en, 1'h1);
	endtask
	task automatic t_scan();
		tst.hold_reset(1'h1);
		repeat (4) @(negedge clk);
		check(scan_enabled, 1'h1);
		tst.step(1'h0);
		check(tdo_oe, 1'h0);
		check(instr === MTPSC_IR_RESET, 1'h1);
		for (i = 0; i < 4; i++) tst.step(i < 2);
		for (i = 0; i < 8 && tdo_oe !== 1'h1; i++) @(negedge clk);
		if (tdo_oe !== 1'h1) begin
			n_errors++;
			complete_run();
		end
		check(tdo_out, MTPSC_IR_RESET[0]);
		pads(1'h1, 1'h1, 1'h1, 1'h1);
		check(tdo_oe, 1'h0);
		pads(1'h1, 1'h1, 1'h0, 1'h0);
		tst.hold_reset(1'h0);
		repeat (6) @(negedge clk);
		check(tdo_oe, 1'h0);
		check(scan_enabled, 1'h0);
	endtask
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	initial begin
		rst_n = 1'h0;
		mdio_read_drive = 1'h1;
		mdio_core_out = 1'h1;
		chan_a_powerdown_pin_low = 1'h1;
		chan_b_powerdown_pin_low = 1'h1;
		chan_a_pd_bit = 1'h0;
		chan_b_pd_bit = 1'h0;
		repeat (4) @(negedge clk);
		check(mdio_oe, 1'h0);
		check(tdo_oe, 1'h0);
		rst_n = 1'h1;
		t_reg_pd();
		t_pin_pd();
		t_scan();
		complete_run();
	end
endmodule
`default_nettype wire

// *** dv/mtpsc_tester.sv ***
`timescale 1ns/1ps
`default_nettype none
module mtpsc_tester (
	input  wire logic clk,            // paces the test clock
	output logic      tck,            // test clock, low when idle
	output logic      tms,            // mode select
	output logic      tdi,            // data in
	output logic      test_reset_low  // test reset
);
	// ==========
	// boundary-scan tester
	initial begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h1;
		test_reset_low = 1'h0;
	end
	task automatic hold_reset(input logic level);
		@(negedge clk);
		test_reset_low = level;
	endtask
	// tms and fresh tdi set while tck low, 360 ns period
	task automatic step(input logic mode);
		@(negedge clk);
		tms = mode;
		tdi = ~tdi;
		repeat (4) @(negedge clk);
		tck = 1'h1;
		repeat (4) @(negedge clk);
		tck = 1'h0;
	endtask
endmodule
`default_nettype wire

// *** hw/mtpsc_pad_ctrl.sv ***
// Overview of operation
// - device reset low: mdio and tdo both undriven
// - both powerdown pins low: mdio and tdo float
// - register powerdown on both channels keeps management access working
// - register powerdown on both channels: mdio still driven on reads
// - status bits may be meaningless in powerdown; software must ignore them
// - tdo floats whenever the test port is not shifting
// - register powerdown on both channels floats tdo
// - tdi/tms pull-ups on in register powerdown, off in pin powerdown
// - test reset pull-down on in register powerdown, off in pin powerdown
// - test reset low returns scan logic to system mode; open stays disabled
// - tms steers the controller; data shifts tdi in, tdo out on tck
`timescale 1ns/1ps
`default_nettype none
module mtpsc_pad_ctrl
	import mtpsc_pkg::*;
#(
	parameter int IR_WIDTH = MTPSC_IR_WIDTH
) (
	input  wire logic clk,                       // 25 MHz system clock
	input  wire logic rst_n,                     // device reset, active low
	input  wire logic chan_a_powerdown_pin_low,  // channel a pin, active low
	input  wire logic chan_b_powerdown_pin_low,  // channel b pin, active low
	input  wire logic chan_a_pd_bit,             // channel a powerdown bit
	input  wire logic chan_b_pd_bit,             // channel b powerdown bit
	input  wire logic mdio_read_drive,           // core wants mdio driven
	input  wire logic mdio_core_out,             // core mdio data
	output logic      mdio_out,                  // mdio pad data
	output logic      mdio_oe,                   // mdio pad enable
	output logic      mgmt_active,               // management usable
	output logic      status_valid,              // status bits meaningful
	input  wire logic tck,                       // test clock pin
	input  wire logic tms,                       // test mode select pin
	input  wire logic tdi,                       // test data in pin
	input  wire logic test_reset_low,            // test reset pin, active low
	output logic      tdo_out,                   // tdo pad data
	output logic      tdo_oe,                    // tdo pad enable
	output logic      tdi_pullup_en,             // tdi pull-up enable
	output logic      tms_pullup_en,             // tms pull-up enable
	output logic      trst_pulldown_en,          // test reset pull-down
	output logic      scan_enabled,              // scan logic active
	output logic [IR_WIDTH-1:0] instr            // current instruction
);
	import mtpsc_pkg::*;

	// ==========================================================
	// input synchronisers
	logic [5:0]    pin_sync;
	mtpsc_tap_type tap_state;
	logic          tck_prev;
	logic          tck_rise;
	logic          tck_fall;
	logic          pin_pd;
	logic          reg_pd;
	logic          pads_off;

	mtpsc_sync #(.WIDTH(6)) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		// powerdown pins go in inverted so the cleared synchroniser
		// reads as no powerdown; a false pin powerdown after reset
		// would drop the pulls for two cycles
		.d     ({~chan_a_powerdown_pin_low, ~chan_b_powerdown_pin_low,
		         tck, tms, tdi, test_reset_low}),
		.q     (pin_sync)
	);

	wire logic s_pda   = pin_sync[5];
	wire logic s_pdb   = pin_sync[4];
	wire logic s_tck   = pin_sync[3];
	wire logic s_tms   = pin_sync[2];
	wire logic s_tdi   = pin_sync[1];
	wire logic s_trstn = pin_sync[0];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tck_prev <= 1'b0;
		end else begin
			tck_prev <= s_tck;
		end
	end
	assign tck_rise = s_tck & ~tck_prev;
	assign tck_fall = ~s_tck & tck_prev;

	// ==========================================================
	// powerdown conditions
	// pin powerdown needs both pins low
	assign pin_pd = s_pda & s_pdb;
	assign reg_pd = chan_a_pd_bit & chan_b_pd_bit;
	assign pads_off = pin_pd;

	// ==========================================================
	// management pad
	// management stays up in register powerdown
	assign mgmt_active = rst_n & ~pin_pd;
	// status bits unreliable in either powerdown
	assign status_valid = rst_n & ~pin_pd & ~reg_pd;

	// reset floats mdio; read drive survives register pd
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mdio_oe  <= 1'b0;
			mdio_out <= 1'b0;
		end else begin
			mdio_oe  <= mdio_read_drive & ~pads_off;
			mdio_out <= mdio_core_out;
		end
	end

	// ==========================================================
	// pull enables
	// pull-ups stay on in register powerdown, removed in pin powerdown
	// pull-down likewise; reset keeps pulls in default state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tdi_pullup_en    <= 1'b1;
			tms_pullup_en    <= 1'b1;
			trst_pulldown_en <= 1'b1;
		end else begin
			tdi_pullup_en    <= ~pin_pd;
			tms_pullup_en    <= ~pin_pd;
			trst_pulldown_en <= ~pin_pd;
		end
	end

	// ==========================================================
	// test port
	// low test reset forces system mode
	assign scan_enabled = s_trstn;

	mtpsc_tap u_tap (
		.clk      (clk),
		.rst_n    (rst_n),
		.trst     (~s_trstn),
		.tck_rise (tck_rise),
		.tms      (s_tms),
		.state    (tap_state)
	);

	logic [IR_WIDTH-1:0] ir_shift;
	logic                dr_bypass;
	logic                shifting;

	// shift tdi in on tck rise
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ir_shift  <= IR_WIDTH'(MTPSC_IR_RESET);
			instr     <= IR_WIDTH'(MTPSC_IR_RESET);
			dr_bypass <= 1'b0;
		end else if (!s_trstn || tap_state == MTPSC_TLR) begin
			ir_shift  <= IR_WIDTH'(MTPSC_IR_RESET);
			instr     <= IR_WIDTH'(MTPSC_IR_RESET);
			dr_bypass <= 1'b0;
		end else if (tck_rise) begin
			unique case (tap_state)
				MTPSC_CIR: ir_shift <= IR_WIDTH'(MTPSC_IR_RESET);
				MTPSC_SIR: ir_shift <= {s_tdi, ir_shift[IR_WIDTH-1:1]};
				MTPSC_UIR: instr <= ir_shift;
				MTPSC_CDR: dr_bypass <= 1'b0;
				MTPSC_SDR: dr_bypass <= s_tdi;
				default: ;
			endcase
		end
	end

	// tdo updates on the falling edge, as the tester samples on the rise
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shifting <= 1'b0;
			tdo_out  <= 1'b0;
		end else if (tck_fall) begin
			shifting <= (tap_state == MTPSC_SIR) || (tap_state == MTPSC_SDR);
			tdo_out  <= (tap_state == MTPSC_SIR) ? ir_shift[0] : dr_bypass;
		end
	end

	// tdo driven only while shifting; floats in register pd
	// reset and pin powerdown float it too
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tdo_oe <= 1'b0;
		end else begin
			tdo_oe <= shifting & s_trstn & ~pads_off & ~reg_pd
				& (tap_state == MTPSC_SIR || tap_state == MTPSC_SDR);
		end
	end

endmodule
`default_nettype wire

// *** hw/mtpsc_pkg.sv ***
package mtpsc_pkg;

	// ==========================================================
	// tap state encoding (ieee 1149.1 controller)
	typedef enum logic [3:0] {
		MTPSC_TLR  = 4'h0,
		MTPSC_RTI  = 4'h1,
		MTPSC_SDS  = 4'h3,
		MTPSC_CDR  = 4'h2,
		MTPSC_SDR  = 4'h6,
		MTPSC_E1D  = 4'h7,
		MTPSC_PDR  = 4'h5,
		MTPSC_E2D  = 4'h4,
		MTPSC_UDR  = 4'hC,
		MTPSC_SIS  = 4'hD,
		MTPSC_CIR  = 4'hF,
		MTPSC_SIR  = 4'hE,
		MTPSC_E1I  = 4'hA,
		MTPSC_PIR  = 4'hB,
		MTPSC_E2I  = 4'h9,
		MTPSC_UIR  = 4'h8
	} mtpsc_tap_type;

	// ==========================================================
	// widths and reset values
	localparam int          MTPSC_IR_WIDTH  = 4;
	localparam logic [3:0]  MTPSC_IR_RESET  = 4'h1;
	localparam logic [3:0]  MTPSC_IR_BYPASS = 4'hF;
	localparam int          MTPSC_SYNC_STAGES = 2;
	// channel count whose powerdown bits must all be set
	localparam int          MTPSC_CHANNELS  = 2;

endpackage

// *** hw/mtpsc_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module mtpsc_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,    // system clock
	input  wire logic             rst_n,  // async reset, active low
	input  wire logic [WIDTH-1:0] d,      // asynchronous level in
	output logic      [WIDTH-1:0] q       // synchronised level out
);
	logic [WIDTH-1:0] stage1;

	// stage1 is read by q only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= '0;
			q      <= '0;
		end else begin
			stage1 <= d;
			q      <= stage1;
		end
	end
endmodule
`default_nettype wire

// *** hw/mtpsc_tap.sv ***
`timescale 1ns/1ps
`default_nettype none
module mtpsc_tap
	import mtpsc_pkg::*;
(
	input  wire logic          clk,       // system clock
	input  wire logic          rst_n,     // async reset, active low
	input  wire logic          trst,      // synchronous tap reset
	input  wire logic          tck_rise,  // one-cycle tck rising edge
	input  wire logic          tms,       // synchronised mode select
	output mtpsc_tap_type      state      // controller state
);
	import mtpsc_pkg::*;

	mtpsc_tap_type next_state;

	always_comb begin
		next_state = state;
		unique case (state)
			MTPSC_TLR: next_state = tms ? MTPSC_TLR : MTPSC_RTI;
			MTPSC_RTI: next_state = tms ? MTPSC_SDS : MTPSC_RTI;
			MTPSC_SDS: next_state = tms ? MTPSC_SIS : MTPSC_CDR;
			MTPSC_CDR: next_state = tms ? MTPSC_E1D : MTPSC_SDR;
			MTPSC_SDR: next_state = tms ? MTPSC_E1D : MTPSC_SDR;
			MTPSC_E1D: next_state = tms ? MTPSC_UDR : MTPSC_PDR;
			MTPSC_PDR: next_state = tms ? MTPSC_E2D : MTPSC_PDR;
			MTPSC_E2D: next_state = tms ? MTPSC_UDR : MTPSC_SDR;
			MTPSC_UDR: next_state = tms ? MTPSC_SDS : MTPSC_RTI;
			MTPSC_SIS: next_state = tms ? MTPSC_TLR : MTPSC_CIR;
			MTPSC_CIR: next_state = tms ? MTPSC_E1I : MTPSC_SIR;
			MTPSC_SIR: next_state = tms ? MTPSC_E1I : MTPSC_SIR;
			MTPSC_E1I: next_state = tms ? MTPSC_UIR : MTPSC_PIR;
			MTPSC_PIR: next_state = tms ? MTPSC_E2I : MTPSC_PIR;
			MTPSC_E2I: next_state = tms ? MTPSC_UIR : MTPSC_SIR;
			MTPSC_UIR: next_state = tms ? MTPSC_SDS : MTPSC_RTI;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= MTPSC_TLR;
		end else if (trst) begin
			state <= MTPSC_TLR;
		end else if (tck_rise) begin
			state <= next_state;
		end
	end
endmodule
`default_nettype wire
